// >>> hdl/sxt_transmitter.sv
// Serial transmitter with Wishbone registers, buffer and frame shifter
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sxt_params.svh"
module sxt_transmitter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output var logic [31:0] wb_dat_o,
  output var logic wb_ack_o,
  output var logic txd_o,
  output var logic txd_oe_o,
  input wire logic port_txd_i,
  input wire logic port_txd_oe_i,
  input wire logic ext_clk_i,
  output var logic ext_clk_o,
  output var logic ext_clk_oe_o,
  input wire logic port_ext_clk_i,
  input wire logic port_ext_clk_oe_i,
  input wire logic ext_clk_master_i,
  output var logic irq_empty_o,
  output var logic irq_done_o,
  input wire logic irq_done_taken_i,
  output var sxt_pkg::sxt_state_t state_o
);
  import sxt_pkg::*;

  function automatic logic [3:0] char_bits(input logic [2:0] code);
    if (code == `SXT_SIZE_NINE) char_bits = 4'h9;
    else if (code > `SXT_SIZE_EIGHT) char_bits = 4'h8;
    else char_bits = {2'b01, code[1:0]} + 4'h1;
  endfunction

  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] control_reg;
  logic [6:0] format_reg;
  logic dbl_speed_reg;
  sxt_div_t divisor_reg;
  sxt_char_t buf_reg;
  logic buf_full_reg;
  sxt_char_t shift_reg;
  logic parity_reg;
  logic [3:0] bit_cnt_reg;
  sxt_state_t state_reg;
  logic done_reg;
  logic on_reg;
  logic [4:0] presc_reg;
  logic clk_out_reg;
  logic base_tick, ext_rise, ext_fall, bit_tick, end_frame, load;
  logic wr_en, data_wr, sync_mode, master, busy, done_clr;
  logic [2:0] size_code;
  logic [3:0] nbits;
  logic [4:0] divide;
  sxt_char_t masked;

  // Bus request accepted one cycle after it appears
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
  assign data_wr = wr_en && wb_adr_i == `SXT_IDX_DATA;
  assign size_code = {control_reg[`SXT_CB_SIZE2],
                      format_reg[`SXT_FF_SIZE1:`SXT_FF_SIZE0]};
  assign nbits = char_bits(size_code);
  assign sync_mode = format_reg[`SXT_FF_SYNC];
  assign master = sync_mode && ext_clk_master_i;
  assign busy = state_reg != ST_IDLE || buf_full_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
      unique case (wb_adr_i)
        `SXT_IDX_STATUS: rdata_reg <= {24'h00_0000, 1'b0, done_reg,
          !buf_full_reg, 3'b000, dbl_speed_reg, 1'b0};
        `SXT_IDX_CONTROL: rdata_reg <= {24'h00_0000, control_reg};
        `SXT_IDX_SHARED: rdata_reg <= {24'h00_0000, 1'b1, format_reg};
        `SXT_IDX_BAUD_LO: rdata_reg <= {24'h00_0000, divisor_reg[7:0]};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Writes to the empty flag position are dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      control_reg <= `SXT_CONTROL_RST;
      format_reg <= `SXT_FORMAT_RST;
      dbl_speed_reg <= 1'b0;
      divisor_reg <= `SXT_DIVISOR_RST;
    end else if (wr_en) begin
      unique case (wb_adr_i)
        `SXT_IDX_STATUS: dbl_speed_reg <= wb_dat_i[`SXT_SA_DBL_SPEED];
        `SXT_IDX_CONTROL: control_reg <= wb_dat_i[7:0];
        `SXT_IDX_SHARED: begin
          if (wb_dat_i[`SXT_FF_SELECT]) begin
            format_reg <= wb_dat_i[6:0];
          end else begin
            divisor_reg[11:8] <= wb_dat_i[3:0];
          end
        end
        `SXT_IDX_BAUD_LO: divisor_reg[7:0] <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  sxt_baud_gen u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .divisor_i(divisor_reg),
    .reload_i(wr_en && wb_adr_i == `SXT_IDX_BAUD_LO),
    .tick_o(base_tick)
  );

  sxt_pin_sync u_ext_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(ext_clk_i),
    .rise_o(ext_rise),
    .fall_o(ext_fall)
  );

  assign divide = dbl_speed_reg ? `SXT_DIV_DOUBLE : `SXT_DIV_NORMAL;

  // Prescaler restarts when idle so the start bit is full length
  always_ff @(posedge clk_i) begin
    if (rst_i || state_reg == ST_IDLE) begin
      presc_reg <= 5'h00;
    end else if (base_tick) begin
      presc_reg <= (presc_reg == divide - 5'h01) ? 5'h00
                   : presc_reg + 5'h01;
    end
  end

  // Master clock toggles on every baud tick, i.e. divide by two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_out_reg <= 1'b0;
    end else if (master && on_reg && base_tick) begin
      clk_out_reg <= !clk_out_reg;
    end
  end

  // Data changes on the edge opposite to the sampling edge
  always_comb begin
    if (!sync_mode) begin
      bit_tick = base_tick && presc_reg == divide - 5'h01;
    end else if (master) begin
      bit_tick = base_tick && clk_out_reg == format_reg[`SXT_FF_CLK_POL];
    end else begin
      bit_tick = format_reg[`SXT_FF_CLK_POL] ? ext_fall : ext_rise;
    end
  end

  assign end_frame = bit_tick && ((state_reg == ST_STOP1
    && !format_reg[`SXT_FF_STOP2]) || state_reg == ST_STOP2);
  assign load = on_reg && buf_full_reg
    && (state_reg == ST_IDLE || end_frame);

  // Upper bits beyond the character size never reach the line
  always_comb begin
    masked = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(nbits)) masked[i] = buf_reg[i];
    end
  end

  // New data wins over a load in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      buf_full_reg <= 1'b0;
      buf_reg <= 9'h000;
    end else if (data_wr) begin
      buf_full_reg <= 1'b1;
      buf_reg <= {control_reg[`SXT_CB_NINTH], wb_dat_i[7:0]};
    end else if (load) begin
      buf_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      shift_reg <= 9'h000;
      parity_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
    end else if (load) begin
      state_reg <= ST_START;
      shift_reg <= masked;
      parity_reg <= ^masked ^ format_reg[`SXT_FF_PAR_ODD];
      bit_cnt_reg <= 4'h0;
    end else if (bit_tick) begin
      unique case (state_reg)
        ST_IDLE: ;
        ST_START: state_reg <= ST_DATA;
        ST_DATA: begin
          shift_reg <= {1'b0, shift_reg[8:1]};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == nbits - 4'h1) begin
            state_reg <= format_reg[`SXT_FF_PAR_EN]
              ? ST_PARITY : ST_STOP1;
          end
        end
        ST_PARITY: state_reg <= ST_STOP1;
        ST_STOP1: begin
          state_reg <= format_reg[`SXT_FF_STOP2] ? ST_STOP2
                       : ST_IDLE;
        end
        ST_STOP2: state_reg <= ST_IDLE;
      endcase
    end
  end

  // A frame completing with the buffer empty wins over a clear in the same cycle
  assign done_clr = irq_done_taken_i || (wr_en
    && wb_adr_i == `SXT_IDX_STATUS && wb_dat_i[`SXT_SA_DONE]);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
    end else if (end_frame && !buf_full_reg) begin
      done_reg <= 1'b1;
    end else if (done_clr) begin
      done_reg <= 1'b0;
    end
  end

  // Clearing the enable waits until nothing is left to send
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_reg <= 1'b0;
    end else if (control_reg[`SXT_CB_XMIT_EN]) begin
      on_reg <= 1'b1;
    end else if (!busy) begin
      on_reg <= 1'b0;
    end
  end

  logic line;
  always_comb begin
    unique case (state_reg)
      ST_START: line = 1'b0;
      ST_DATA: line = shift_reg[0];
      ST_PARITY: line = parity_reg;
      default: line = 1'b1;
    endcase
  end

  assign txd_o = on_reg ? line : port_txd_i;
  assign txd_oe_o = on_reg ? 1'b1 : port_txd_oe_i;
  assign ext_clk_o = (on_reg && master) ? clk_out_reg
                     : port_ext_clk_i;
  assign ext_clk_oe_o = (on_reg && sync_mode) ? master
                        : port_ext_clk_oe_i;
  assign irq_empty_o = control_reg[`SXT_CB_EMPTY_IE]
    && !buf_full_reg;
  assign irq_done_o = control_reg[`SXT_CB_DONE_IE] && done_reg;
  assign state_o = state_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_frame_end;
    end_frame;
  endsequence
  sequence s_data_write;
    data_wr;
  endsequence

  a_parity_slot: assert property (state_reg == ST_PARITY |->
    format_reg[`SXT_FF_PAR_EN] && $past(state_reg) != ST_STOP1)
    else $error("parity slot without parity enable");
  a_start_low: assert property (on_reg && state_reg == ST_START
    |-> !txd_o) else $error("start bit not low");
  a_stop_high: assert property (on_reg && (state_reg == ST_STOP1
    || state_reg == ST_STOP2) |-> txd_o) else $error("stop bit not high");
  a_empty_flag: assert property (s_data_write |=>
    !irq_empty_o || !control_reg[`SXT_CB_EMPTY_IE])
    else $error("empty flag not cleared by write");
  a_empty_irq: assert property (control_reg[`SXT_CB_EMPTY_IE]
    && !buf_full_reg |-> irq_empty_o) else $error("empty irq missing");
  a_done_set: assert property (s_frame_end ##0 !buf_full_reg
    |=> done_reg) else $error("done flag not set after frame");
  a_done_clear: assert property (irq_done_taken_i && !end_frame
    |=> !done_reg) else $error("done flag not cleared");
  a_pin_owned: assert property (on_reg |-> txd_oe_o)
    else $error("enabled transmitter not driving pin");
  a_back_to_back: assert property (s_frame_end ##0 load
    |=> state_reg == ST_START) else $error("no back-to-back frame");
  a_late_release: assert property ($fell(on_reg) |->
    $past(state_reg) == ST_IDLE && !$past(buf_full_reg))
    else $error("disabled while data pending");
  a_idle_high: assert property (on_reg && state_reg == ST_IDLE
    |-> txd_o) else $error("idle line not high");
  a_format_write: assert property (wr_en && wb_adr_i == `SXT_IDX_SHARED
    && wb_dat_i[`SXT_FF_SELECT] |=> format_reg == $past(wb_dat_i[6:0]))
    else $error("format write lost");
  a_size_mask: assert property (load ##0 nbits < 4'h9
    |=> shift_reg[8] == 1'b0) else $error("upper bits not masked");
endmodule
`default_nettype wire

// >>> hdl/sxt_params.svh
// Register offsets, field positions and reset values of the transmitter
`ifndef SXT_PARAMS_SVH
`define SXT_PARAMS_SVH
// Word indices, byte address is four times the index
`define SXT_IDX_DATA 3'h0
`define SXT_IDX_STATUS 3'h1
`define SXT_IDX_CONTROL 3'h2
`define SXT_IDX_SHARED 3'h3
`define SXT_IDX_BAUD_LO 3'h4
// Status A fields
`define SXT_SA_DONE 6
`define SXT_SA_EMPTY 5
`define SXT_SA_DBL_SPEED 1
// Control B fields
`define SXT_CB_DONE_IE 6
`define SXT_CB_EMPTY_IE 5
`define SXT_CB_XMIT_EN 3
`define SXT_CB_SIZE2 2
`define SXT_CB_NINTH 0
// Frame format fields
`define SXT_FF_SELECT 7
`define SXT_FF_SYNC 6
`define SXT_FF_PAR_EN 5
`define SXT_FF_PAR_ODD 4
`define SXT_FF_STOP2 3
`define SXT_FF_SIZE1 2
`define SXT_FF_SIZE0 1
`define SXT_FF_CLK_POL 0
// Reset values
`define SXT_CONTROL_RST 8'h00
`define SXT_FORMAT_RST 7'h06
`define SXT_DIVISOR_RST 12'h000
// Bit clock division and size codes
`define SXT_DIV_NORMAL 5'h10
`define SXT_DIV_DOUBLE 5'h08
`define SXT_SIZE_NINE 3'h7
`define SXT_SIZE_EIGHT 3'h3
`endif

// >>> hdl/sxt_pkg.sv
// Types shared by the serial transmitter modules
package sxt_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP1, ST_STOP2
  } sxt_state_t;
  typedef logic [11:0] sxt_div_t;
  typedef logic [8:0] sxt_char_t;
endpackage

// >>> hdl/sxt_baud_gen.sv
// Programmable down-counter producing the baud generator tick
`timescale 1ns/1ps
`default_nettype none
module sxt_baud_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sxt_pkg::sxt_div_t divisor_i,
  input wire logic reload_i,
  output var logic tick_o
);
  import sxt_pkg::*;
  sxt_div_t cnt_reg;
  logic tick_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= `SXT_DIVISOR_RST;
    end else if (reload_i || cnt_reg == 12'h000) begin
      cnt_reg <= divisor_i;
    end else begin
      cnt_reg <= cnt_reg - 12'h001;
    end
  end

  // One tick per divisor+1 system clocks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (cnt_reg == 12'h000) && !reload_i;
    end
  end

  assign tick_o = tick_reg;
endmodule
`default_nettype wire

// >>> hdl/sxt_pin_sync.sv
// Two-stage synchroniser with edge detection for the external clock pin
`timescale 1ns/1ps
`default_nettype none
module sxt_pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output var logic rise_o,
  output var logic fall_o
);
  import sxt_pkg::*;
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edges seen only behind the second stage
  assign rise_o = sync_reg && !prev_reg;
  assign fall_o = !sync_reg && prev_reg;
endmodule
`default_nettype wire

// >>> verification/sxt_rx_model.sv
// Behavioural remote receiver that samples the serial line mid-bit
`timescale 1ns/1ps
`default_nettype none
module sxt_rx_model (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic [4:0] bit_clks_i,
  input wire logic [3:0] nbits_i,
  input wire logic par_en_i,
  input wire logic stop2_i,
  output var logic [8:0] data_o,
  output var logic par_o,
  output var logic [1:0] stop_o,
  output var logic [7:0] gap_o,
  output var logic [7:0] count_o
);
  int g;
  initial begin
    count_o = 8'h00;
    forever begin
      g = 0;
      @(posedge clk_i);
      while (line_i !== 1'h0) begin
        @(posedge clk_i);
        if (g < 255) g++;
      end
      // Idle time since the last stop sample shows back-to-back frames
      gap_o = 8'(g);
      repeat (bit_clks_i / 2) @(posedge clk_i);
      data_o = 9'h000;
      for (int i = 0; i < nbits_i; i++) begin
        repeat (bit_clks_i) @(posedge clk_i);
        data_o[i] = line_i;
      end
      par_o = 1'h0;
      if (par_en_i) begin
        repeat (bit_clks_i) @(posedge clk_i);
        par_o = line_i;
      end
      repeat (bit_clks_i) @(posedge clk_i);
      stop_o = {1'h1, line_i};
      if (stop2_i) begin
        repeat (bit_clks_i) @(posedge clk_i);
        stop_o[1] = line_i;
      end
      count_o = count_o + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the serial transmitter with a remote receiver
`timescale 1ns/1ps
`default_nettype none
`include "sxt_params.svh"
module tb_top;
  import sxt_pkg::*;
  logic clk_i = 1'h0, rst_i = 1'h1, line, odd, ie, dbl;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic [4:2] wb_adr_i = 3'h0;
  logic [3:0] wb_sel_i = 4'h0, nbits = 4'h8;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, txd_o, txd_oe_o, irq_empty_o, irq_done_o;
  logic port_txd_oe_i = 1'h0, irq_done_taken_i = 1'h0;
  logic par_en = 1'h0, stop2 = 1'h0, rx_par;
  logic [4:0] bitc = 5'h10;
  logic ext_clk_master_i = 1'h0, ext_clk_o, ext_clk_oe_o, ck;
  logic [8:0] rx_data, d0, d1;
  logic [1:0] rx_stop;
  logic [7:0] rx_gap, rx_cnt, fmt, ctl;
  logic [2:0] code;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
  sxt_state_t state_o;
  int errors = 0, checks_done = 0, k;
  always #50 clk_i = ~clk_i;
  // Released pin floats high through the pull-up
  assign line = txd_oe_o ? txd_o : 1'h1;
  sxt_transmitter i_sxt_transmitter (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .txd_o(txd_o),
    .txd_oe_o(txd_oe_o), .port_txd_i(1'h1), .port_txd_oe_i(port_txd_oe_i),
    .ext_clk_i(1'h0), .ext_clk_o(ext_clk_o), .ext_clk_oe_o(ext_clk_oe_o),
    .port_ext_clk_i(1'h0), .port_ext_clk_oe_i(1'h0),
    .ext_clk_master_i(ext_clk_master_i),
    .irq_empty_o(irq_empty_o), .irq_done_o(irq_done_o),
    .irq_done_taken_i(irq_done_taken_i), .state_o(state_o));
  sxt_rx_model i_sxt_rx_model (.clk_i(clk_i), .line_i(line),
    .bit_clks_i(bitc), .nbits_i(nbits), .par_en_i(par_en), .stop2_i(stop2),
    .data_o(rx_data), .par_o(rx_par), .stop_o(rx_stop), .gap_o(rx_gap),
    .count_o(rx_cnt));
  task automatic stop_test();
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [2:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    logic [31:0] r;
    n = 0;
    r = $urandom();
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {r[31:8], d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    if (n >= 20) errors++;
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, string what);
    logic [7:0] q;
    wb(1'h0, a, 8'h00, q);
    chk({1'h0, q}, {1'h0, e}, what);
  endtask
  function automatic logic [8:0] msk(input logic [8:0] d);
    return d & (9'h1FF >> (4'h9 - nbits));
  endfunction
  task automatic frame(input logic [8:0] d);
    logic [7:0] c;
    int n;
    c = rx_cnt;
    n = 0;
    while (rx_cnt === c && n < 1000) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 1000) errors++;
    chk(rx_data, msk(d), "data");
    chk({8'h0, rx_par}, {8'h0, par_en & (^msk(d) ^ odd)}, "par");
    chk({7'h0, rx_stop}, 9'h003, "stop bits");
  endtask
  initial begin
    #(100 * 60000);
    errors++;
    stop_test();
  end
  initial begin
    k = $urandom(11);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(`SXT_IDX_STATUS, 8'h20, "reset status");
    rd(`SXT_IDX_SHARED, 8'h86, "reset format");
    wr(`SXT_IDX_SHARED, 8'h0F);
    rd(`SXT_IDX_SHARED, 8'h86, "format kept");
    wr(`SXT_IDX_SHARED, 8'h00);
    wr(`SXT_IDX_BAUD_LO, 8'h00);
    @(negedge clk_i);
    chk({8'h0, txd_oe_o}, {8'h0, port_txd_oe_i}, "pin free");
    for (k = 0; k < 12; k++) begin
      code = codes[$urandom_range(4)];
      nbits = (code == 3'h7) ? 4'h9 : {1'h0, code} + 4'h5;
      {odd, ie} = 2'($urandom());
      {dbl, stop2, par_en} = 3'(k);
      bitc = dbl ? 5'h08 : 5'h10;
      d0 = (k == 0) ? 9'h1FF : 9'($urandom());
      d1 = 9'($urandom());
      fmt = {2'h2, par_en, odd, stop2, code[1:0], 1'h0};
      ctl = {1'h0, ie, ie, 2'h1, code[2], 1'h0, d0[8]};
      wr(`SXT_IDX_SHARED, fmt);
      wr(`SXT_IDX_CONTROL, ctl);
      wr(`SXT_IDX_STATUS, {6'h10, dbl, 1'h0});
      @(negedge clk_i);
      chk({8'h0, line}, 9'h001, "idle line");
      chk({8'h0, txd_oe_o}, 9'h001, "pin taken");
      chk({6'h0, state_o}, {6'h0, ST_IDLE}, "early send");
      wr(`SXT_IDX_DATA, d0[7:0]);
      ctl[0] = d1[8];
      wr(`SXT_IDX_CONTROL, ctl);
      wr(`SXT_IDX_DATA, d1[7:0]);
      rd(`SXT_IDX_STATUS, {6'h00, dbl, 1'h0}, "buffer full");
      frame(d0);
      frame(d1);
      chk({8'h0, rx_gap < 8'h0C}, 9'h001, "back to back");
      repeat (2 * bitc) @(negedge clk_i);
      chk({7'h0, irq_done_o, irq_empty_o}, {7'h0, ie, ie}, "irq");
      rd(`SXT_IDX_STATUS, {6'h18, dbl, 1'h0}, "done set");
      if (k[2]) begin
        @(posedge clk_i);
        irq_done_taken_i <= 1'h1;
        @(posedge clk_i);
        irq_done_taken_i <= 1'h0;
      end else begin
        wr(`SXT_IDX_STATUS, {6'h10, dbl, 1'h0});
      end
      rd(`SXT_IDX_STATUS, {6'h08, dbl, 1'h0}, "done clear");
    end
    // Idle line, so the clock pin may be taken over for a short look
    wr(`SXT_IDX_SHARED, fmt | 8'h40);
    ext_clk_master_i <= 1'h1;
    @(negedge clk_i);
    chk({8'h0, ext_clk_oe_o}, 9'h001, "clock pin taken");
    ck = ext_clk_o;
    @(negedge clk_i);
    chk({8'h0, ext_clk_o}, {8'h0, !ck}, "master clock");
    @(posedge clk_i);
    ext_clk_master_i <= 1'h0;
    wr(`SXT_IDX_SHARED, fmt);
    port_txd_oe_i <= 1'($urandom());
    d0 = {ctl[0], 8'hA5};
    wr(`SXT_IDX_DATA, 8'hA5);
    ctl[3] = 1'h0;
    wr(`SXT_IDX_CONTROL, ctl);
    @(negedge clk_i);
    chk({8'h0, txd_oe_o}, 9'h001, "held while busy");
    frame(d0);
    repeat (3 * bitc) @(negedge clk_i);
    chk({8'h0, txd_oe_o}, {8'h0, port_txd_oe_i}, "released");
    stop_test();
  end
endmodule
`default_nettype wire
